// ---- intarb_pkg.sv ----
// Constants and state layout for the interrupt arbitration block
package intarb_pkg;
  // Register word indexes; byte address is four times the index
  localparam logic [7:0] IDX_TMR_CTL = 8'h88;
  localparam logic [7:0] IDX_AUX0 = 8'hA1;
  localparam logic [7:0] IDX_IEN_MAIN = 8'hA8;
  localparam logic [7:0] IDX_IPH = 8'hB7;
  localparam logic [7:0] IDX_IPL = 8'hB8;
  localparam logic [7:0] IDX_X23_CTL = 8'hC0;
  localparam logic [7:0] IDX_ISTAT = 8'hD0;
  localparam logic [7:0] IDX_IMASK = 8'hD1;
  localparam logic [7:0] IDX_SVC = 8'hD2;
  // Address split
  localparam int unsigned ADDR_LSB = 2;
  localparam int unsigned IDX_W = 8;
  // Enable register fields
  localparam int unsigned IEN_GLOBAL = 7;
  localparam logic [7:0] IEN_RSV_MSK = 8'h40;
  localparam int unsigned IEN_EXT0 = 0;
  localparam int unsigned IEN_TMR0 = 1;
  localparam int unsigned IEN_EXT1 = 2;
  localparam int unsigned IEN_TMR1 = 3;
  localparam int unsigned IEN_SER0 = 4;
  localparam int unsigned IEN_TMR2 = 5;
  // Timer control fields
  localparam int unsigned TC_TYPE0 = 0;
  localparam int unsigned TC_PEND0 = 1;
  localparam int unsigned TC_TYPE1 = 2;
  localparam int unsigned TC_PEND1 = 3;
  // Aux control fields
  localparam int unsigned AX_P0H = 0;
  localparam int unsigned AX_P1H = 1;
  // Ext 2/3 control fields
  localparam int unsigned XC_TYPE2 = 0;
  localparam int unsigned XC_PEND2 = 1;
  localparam int unsigned XC_EN2 = 2;
  localparam int unsigned XC_P2H = 3;
  localparam int unsigned XC_TYPE3 = 4;
  localparam int unsigned XC_PEND3 = 5;
  localparam int unsigned XC_EN3 = 6;
  localparam int unsigned XC_P3H = 7;
  // Source numbers, also the polling order
  localparam logic [2:0] SRC_EXT0 = 3'h0;
  localparam logic [2:0] SRC_EXT1 = 3'h2;
  localparam logic [2:0] SRC_EXT2 = 3'h6;
  localparam logic [2:0] SRC_EXT3 = 3'h7;
  localparam int unsigned N_SRC = 8;
  localparam int unsigned N_LVL = 4;
  // Whole block state
  typedef struct packed {
    logic [7:0] tmr_ctl;
    logic [7:0] aux0;
    logic [7:0] ien;
    logic [7:0] iph;
    logic [7:0] ipl;
    logic [7:0] x23_ctl;
    logic [3:0] ist;
    logic [3:0] imsk;
    logic [3:0] syn1;
    logic [3:0] syn2;
    logic [3:0] prv;
    logic [7:0] smp;
    logic [3:0] insvc;
    logic blk;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic vreq;
    logic [2:0] vsrc;
    logic [1:0] vlvl;
    logic wake;
    logic irq;
  } intarb_st_t;
  // Every register resets to zero; the top module loads the pin history registers high instead
  localparam intarb_st_t ST_RST = '0;
endpackage : intarb_pkg

// ---- intarb_top.sv ----
// Interrupt sampling, arbitration and external input logic
//
// Function
// - Sample flags each clock, poll next clock
// - Block call while equal/higher level serviced
// - Call only on instruction's last cycle
// - After return or an enable, priority or ext2/3 control write, one more instruction
// - Type bit: 0 level, 1 edge
// - Polarity bit 1 selects high/rising detection
// - Ext0/1 flag set; edge flag cleared on service
// - Ext2/3 flag set by edge or level per type bit, service-cleared, software writable
// - Idle wake from ext2/3 only if enabled
// - Global enable gates the service call of every source
// - Enable bits 5..0 per basic source
// - Ext2/3 enable, flag, type, polarity fields
// - Priority bit per source, matching positions
// - High,low bit pair: 11 highest level
// - Higher level first, ties by polling order
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module intarb_top #(
  parameter int unsigned ADDR_W = 12
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // External interrupt pins, asynchronous
  input wire logic ext_irq_input_0_in,
  input wire logic ext_irq_input_1_in,
  input wire logic ext_irq_input_2_in,
  input wire logic ext_irq_input_3_in,
  // Peripheral flags: timer0, timer1, serial0, timer2
  input wire logic [3:0] periph_flag_in,
  // CPU sequencer status
  input wire logic cpu_last_cycle_in,
  input wire logic cpu_reti_in,
  input wire logic idle_mode_in,
  input wire logic power_down_mode_in,
  // Service call to the CPU
  output logic vec_req_out,
  output logic [2:0] vec_src_out,
  output logic [1:0] vec_lvl_out,
  output logic wake_out,
  // Event interrupt line
  output logic irq_out
);

  // Registered state of the whole block
  intarb_pkg::intarb_st_t q;
  // Next state, filled by the single combinational process
  intarb_pkg::intarb_st_t d;

  // Bus decode helpers
  // Setup phase seen this cycle
  logic setup;
  // Write in its access cycle, the edge where it lands
  logic wr;
  // Address inside the register page and word aligned
  logic hit;
  // Word index names a register
  logic mapped;
  // Write to a register that holds off vectoring
  logic cfg_wr;
  // Word index taken from the byte address
  logic [intarb_pkg::IDX_W-1:0] idx;
  // Read mux result
  logic [7:0] rd;
  // Low byte of the write data
  logic [7:0] wd;

  // External input helpers
  // Raw pin levels gathered into one vector
  logic [3:0] pins;
  // Trigger type per input, 1 for edge
  logic [3:0] typ;
  // Polarity per input, 1 for high or rising
  logic [3:0] polh;
  // Pending flags after any software write
  logic [3:0] pend;
  // Input active now, after polarity
  logic [3:0] act;
  // Input active one clock earlier, after polarity
  logic [3:0] actp;
  // Detected trigger per input
  logic [3:0] trig;
  // Flag clear caused by the service call
  logic [3:0] vclr;
  // Next pending flags
  logic [3:0] np;

  // Arbitration helpers
  // Enabled requests seen this clock
  logic [7:0] req;
  // Level of the source looked at in the search
  logic [1:0] lvl;
  // Best level found so far
  logic [1:0] bl;
  // Source number of the best request
  logic [2:0] bi;
  // At least one sampled request exists
  logic found;
  // A level at or above the winner is in service
  logic lvl_blk;
  // Service call issued at this edge
  logic fire;
  // Highest level now in service
  logic [1:0] top;

  // Raw pins gathered into one vector; active level chosen later
  assign pins = {ext_irq_input_3_in, ext_irq_input_2_in,
                 ext_irq_input_1_in, ext_irq_input_0_in};

  // Next-state logic for the whole block
  always_comb begin
    d = q;
    // Search helper starts from a known value
    lvl = 2'b00;
    // Bus phase and address decode
    setup = psel_in & ~penable_in;
    // A write lands in the access cycle, where ready is high
    wr = psel_in & penable_in & q.pready & pwrite_in;
    idx = paddr_in[intarb_pkg::IDX_W+intarb_pkg::ADDR_LSB-1:intarb_pkg::ADDR_LSB];
    // Upper address bits and byte offset must be zero
    hit = (paddr_in[ADDR_W-1:intarb_pkg::IDX_W+intarb_pkg::ADDR_LSB] == '0) &&
          (paddr_in[intarb_pkg::ADDR_LSB-1:0] == '0);
    // Registers are one byte wide; upper write data is ignored
    wd = pwdata_in[7:0];
    // Read mux; unmapped words read zero
    mapped = hit;
    unique case (idx)
      // Timer and external 0/1 control
      intarb_pkg::IDX_TMR_CTL: rd = q.tmr_ctl;
      // Polarity of inputs 0 and 1
      intarb_pkg::IDX_AUX0: rd = q.aux0;
      // Global and basic enables
      intarb_pkg::IDX_IEN_MAIN: rd = q.ien;
      // Priority bit pairs
      intarb_pkg::IDX_IPH: rd = q.iph;
      intarb_pkg::IDX_IPL: rd = q.ipl;
      // External 2/3 control
      intarb_pkg::IDX_X23_CTL: rd = q.x23_ctl;
      // Own status, mask and service registers
      intarb_pkg::IDX_ISTAT: rd = {4'h0, q.ist};
      intarb_pkg::IDX_IMASK: rd = {4'h0, q.imsk};
      intarb_pkg::IDX_SVC: rd = {3'h0, q.blk, q.insvc};
      default: begin
        // No register here: error response
        rd = 8'h00;
        mapped = 1'b0;
      end
    endcase
    // Out-of-page addresses read zero whatever the index
    if (!hit) begin
      rd = 8'h00;
    end
    // No wait state: answer in the first access cycle
    d.pready = setup;
    d.pslverr = setup & ~mapped;
    // Read data is captured at setup and held until the next setup
    if (setup) begin
      d.prdata = {24'h000000, rd};
    end
    // Writes to configuration that hold off vectoring
    cfg_wr = wr & hit & ((idx == intarb_pkg::IDX_IEN_MAIN) ||
             (idx == intarb_pkg::IDX_IPH) ||
             (idx == intarb_pkg::IDX_IPL) ||
             (idx == intarb_pkg::IDX_X23_CTL));
    // Register writes; the service register is read-only
    if (wr && mapped) begin
      unique case (idx)
        intarb_pkg::IDX_TMR_CTL: d.tmr_ctl = wd;
        intarb_pkg::IDX_AUX0: d.aux0 = wd;
        // Reserved bit kept at zero
        intarb_pkg::IDX_IEN_MAIN: d.ien = wd & ~intarb_pkg::IEN_RSV_MSK;
        intarb_pkg::IDX_IPH: d.iph = wd;
        intarb_pkg::IDX_IPL: d.ipl = wd;
        // Software may set or clear the 2/3 pending flags here
        intarb_pkg::IDX_X23_CTL: d.x23_ctl = wd;
        // Status bits clear on a written one
        intarb_pkg::IDX_ISTAT: d.ist = q.ist & ~wd[3:0];
        intarb_pkg::IDX_IMASK: d.imsk = wd[3:0];
        // Service register and others: nothing stored
        default: d.imsk = d.imsk;
      endcase
    end

    // Requests gated by own enables and global enable
    req[0] = q.tmr_ctl[intarb_pkg::TC_PEND0] & q.ien[intarb_pkg::IEN_EXT0];
    req[1] = periph_flag_in[0] & q.ien[intarb_pkg::IEN_TMR0];
    req[2] = q.tmr_ctl[intarb_pkg::TC_PEND1] & q.ien[intarb_pkg::IEN_EXT1];
    req[3] = periph_flag_in[1] & q.ien[intarb_pkg::IEN_TMR1];
    req[4] = periph_flag_in[2] & q.ien[intarb_pkg::IEN_SER0];
    req[5] = periph_flag_in[3] & q.ien[intarb_pkg::IEN_TMR2];
    // External 2/3 enables live in their own control register
    req[6] = q.x23_ctl[intarb_pkg::XC_PEND2] & q.x23_ctl[intarb_pkg::XC_EN2];
    req[7] = q.x23_ctl[intarb_pkg::XC_PEND3] & q.x23_ctl[intarb_pkg::XC_EN3];
    // Global enable cleared: nothing requests at all
    if (!q.ien[intarb_pkg::IEN_GLOBAL]) begin
      req = 8'h00;
    end
    // Samples taken this clock are polled next clock
    d.smp = req;

    // Pick highest level, lowest number on ties
    // The search walks the polling order, so the first winner holds ties
    found = 1'b0;
    bl = 2'b00;
    bi = 3'h0;
    for (int i = 0; i < intarb_pkg::N_SRC; i++) begin
      // High bit then low bit forms the level
      lvl = {q.iph[i], q.ipl[i]};
      if (q.smp[i] && (!found || (lvl > bl))) begin
        found = 1'b1;
        bl = lvl;
        bi = 3'(i);
      end
    end
    // Any level in service at or above the winner
    // A lower level never preempts a routine already running
    lvl_blk = 1'b0;
    for (int k = 0; k < intarb_pkg::N_LVL; k++) begin
      if (q.insvc[k] && (2'(k) >= bl)) begin
        lvl_blk = 1'b1;
      end
    end
    // Issue the call only when nothing blocks it
    // The last-cycle term lets the current instruction finish first
    fire = found & ~lvl_blk & cpu_last_cycle_in
         & ~cpu_reti_in & ~q.blk & ~cfg_wr;
    d.vreq = fire;
    if (fire) begin
      d.vsrc = bi;
      d.vlvl = bl;
      d.insvc[bl] = 1'b1;
    end
    // Release the topmost level at return completion
    // Nested routines return in reverse order, so the top one ends first
    top = 2'b00;
    for (int k = 0; k < intarb_pkg::N_LVL; k++) begin
      if (q.insvc[k]) begin
        top = 2'(k);
      end
    end
    if (cpu_last_cycle_in && cpu_reti_in) begin
      d.insvc[top] = 1'b0;
    end
    // Hold-off: one full instruction must follow
    // Cleared at the end of the next instruction, which is not vectored
    if (cpu_last_cycle_in) begin
      d.blk = 1'b0;
    end
    if (cfg_wr || (cpu_last_cycle_in && cpu_reti_in)) begin
      d.blk = 1'b1;
    end

    // Two-flop synchroniser, then edge history
    // Only the second stage feeds logic; the first may be metastable
    d.syn1 = pins;
    d.syn2 = q.syn1;
    d.prv = q.syn2;
    // Per-input type, polarity and current flag
    // Taken from the next state so a software write counts at once
    typ = {d.x23_ctl[intarb_pkg::XC_TYPE3], d.x23_ctl[intarb_pkg::XC_TYPE2],
           d.tmr_ctl[intarb_pkg::TC_TYPE1], d.tmr_ctl[intarb_pkg::TC_TYPE0]};
    polh = {d.x23_ctl[intarb_pkg::XC_P3H], d.x23_ctl[intarb_pkg::XC_P2H],
            d.aux0[intarb_pkg::AX_P1H], d.aux0[intarb_pkg::AX_P0H]};
    pend = {d.x23_ctl[intarb_pkg::XC_PEND3], d.x23_ctl[intarb_pkg::XC_PEND2],
            d.tmr_ctl[intarb_pkg::TC_PEND1], d.tmr_ctl[intarb_pkg::TC_PEND0]};
    // Active level after polarity choice
    act = (q.syn2 & polh) | (~q.syn2 & ~polh);
    actp = (q.prv & polh) | (~q.prv & ~polh);
    // Edge when type set, level otherwise
    trig = (typ & act & ~actp) | (~typ & act);
    // Serviced inputs lose their flag
    vclr = {fire && (bi == intarb_pkg::SRC_EXT3),
            fire && (bi == intarb_pkg::SRC_EXT2),
            fire && (bi == intarb_pkg::SRC_EXT1),
            fire && (bi == intarb_pkg::SRC_EXT0)};
    // Clear first, then a trigger sets again
    // A trigger in the same cycle as a clear is never lost
    np = (pend & ~vclr) | trig;
    // Inputs 0 and 1 in level mode follow the line
    for (int e = 0; e < 2; e++) begin
      if (!typ[e]) begin
        np[e] = act[e];
      end
    end
    // Flags written back into their home registers
    d.tmr_ctl[intarb_pkg::TC_PEND0] = np[0];
    d.tmr_ctl[intarb_pkg::TC_PEND1] = np[1];
    d.x23_ctl[intarb_pkg::XC_PEND2] = np[2];
    d.x23_ctl[intarb_pkg::XC_PEND3] = np[3];

    // Trigger events are sticky; set wins over clear
    d.ist = d.ist | trig;
    // Level interrupt, registered so the output comes from a flop
    d.irq = |(d.ist & d.imsk);
    // Wake only for enabled ext2/3 during sleep
    d.wake = (idle_mode_in | power_down_mode_in) &
             ((np[2] & d.x23_ctl[intarb_pkg::XC_EN2]) |
              (np[3] & d.x23_ctl[intarb_pkg::XC_EN3]));
  end

  // State register, synchronous reset
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      q <= intarb_pkg::ST_RST;
      // Pin history starts at the idle high level
      // Avoids a false trigger on low-active inputs after reset
      q.syn1 <= 4'hF;
      q.syn2 <= 4'hF;
      q.prv <= 4'hF;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from flops
  assign prdata_out = q.prdata;
  assign pready_out = q.pready;
  assign pslverr_out = q.pslverr;
  assign vec_req_out = q.vreq;
  assign vec_src_out = q.vsrc;
  assign vec_lvl_out = q.vlvl;
  assign wake_out = q.wake;
  assign irq_out = q.irq;

endmodule : intarb_top
`default_nettype wire

// ---- intarb_chk.sv ----
// Port checker for the interrupt arbitration block
`timescale 1ns/1ps
`default_nettype none
module intarb_chk (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Watched ports
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic cpu_last_cycle_in,
  input wire logic cpu_reti_in,
  input wire logic vec_req_out,
  input wire logic [2:0] vec_src_out,
  input wire logic irq_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // Return executing in its last cycle
  logic rl_q;
  logic rl_d;
  assign rl_d = cpu_reti_in && cpu_last_cycle_in;
  always_ff @(posedge clk_in) begin
    rl_q <= rl_d;
  end
  AST_SETUP: assert property (psel_in && !penable_in |=> pready_out) else $error("no ready after setup");
  AST_ONE: assert property (pready_out |=> !pready_out) else $error("ready longer than one cycle");
  AST_CAUSE: assert property (pready_out |-> $past(psel_in) && !$past(penable_in)) else $error("stray ready");
  AST_ERR: assert property (pslverr_out |-> pready_out) else $error("error without ready");
  AST_LAST: assert property (vec_req_out |-> $past(cpu_last_cycle_in)) else $error("call off last cycle");
  AST_RETI: assert property (vec_req_out |-> !$past(cpu_reti_in)) else $error("call on return");
  AST_AFTER: assert property (vec_req_out |-> !$past(rl_q)) else $error("call right after return");
  AST_HOLD: assert property (!vec_req_out |-> $stable(vec_src_out)) else $error("source moved");
  // Main scenarios
  cover property (vec_req_out);
  cover property (pslverr_out);
  cover property (irq_out);
endmodule : intarb_chk
`default_nettype wire

// ---- intarb_cpu_model.sv ----
// CPU sequencer model: two-cycle instructions, return on command
`timescale 1ns/1ps
`default_nettype none
module intarb_cpu_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Return request from the bench
  input wire logic ret_in,
  // Sequencer status
  output logic last_out,
  output logic reti_out
);
  // Last cycle every other clock; return held through its last cycle
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      last_out <= 1'b0;
      reti_out <= 1'b0;
    end else begin
      last_out <= !last_out;
      if (ret_in) begin
        reti_out <= 1'b1;
      end else if (last_out) begin
        reti_out <= 1'b0;
      end
    end
  end
endmodule : intarb_cpu_model
`default_nettype wire

// ---- intarb_tb_top.sv ----
// Testbench for the interrupt arbitration block
`timescale 1ns/1ps
`default_nettype none
module intarb_tb_top;
  logic clk_in, rst_n_in, psel, pen, pwr, ret, idle, pin0, pin2, last, reti, got, e;
  logic [11:0] pa;
  logic [31:0] pwd, prd, r;
  logic [3:0] fl;
  logic [2:0] src;
  logic [1:0] lvl;
  logic rdy, serr, vreq, wake, irq;
  int err_count, checked;
  intarb_top dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
    .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd), .pready_out(rdy), .pslverr_out(serr),
    .ext_irq_input_0_in(pin0), .ext_irq_input_1_in(1'b1), .ext_irq_input_2_in(pin2),
    .ext_irq_input_3_in(1'b1), .periph_flag_in(fl), .cpu_last_cycle_in(last), .cpu_reti_in(reti),
    .idle_mode_in(idle), .power_down_mode_in(1'b0), .vec_req_out(vreq), .vec_src_out(src),
    .vec_lvl_out(lvl), .wake_out(wake), .irq_out(irq));
  intarb_cpu_model cpu (.clk_in(clk_in), .rst_n_in(rst_n_in), .ret_in(ret), .last_out(last), .reti_out(reti));
  // Clock
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = !clk_in;
  end
  task tally_and_finish;
    $display("checked %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  task chk(input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x) begin
      err_count++;
      $display("mismatch at %0t seen %h expected %h", $time, s, x);
    end
  endtask : chk
  // One APB transfer, bounded wait for ready
  task apb(input logic w, input logic [7:0] i, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= w;
    pa <= {2'h0, i, 2'h0};
    pwd <= {24'h0, d};
    @(posedge clk_in);
    pen <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
    end while (rdy !== 1'b1 && n < 20);
    r = prd;
    e = serr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk_in);
    if (n == 20) begin
      err_count++;
      tally_and_finish();
    end
  endtask : apb
  // Watch n cycles for a service call
  task wv(input int n);
    got = 1'b0;
    repeat (n) begin
      @(posedge clk_in);
      if (vreq === 1'b1) begin
        got = 1'b1;
        break;
      end
    end
  endtask : wv
  task pulse_ret;
    ret <= 1'b1;
    @(posedge clk_in);
    ret <= 1'b0;
    repeat (6) @(posedge clk_in);
  endtask : pulse_ret
  task s_regs;
    logic [7:0] ix [6] = '{8'h88, 8'hA1, 8'hA8, 8'hB7, 8'hB8, 8'hC0};
    foreach (ix[k]) begin
      apb(1'b0, ix[k], 8'h00);
      chk(r, 32'h0);
    end
    apb(1'b0, 8'h10, 8'h00);
    chk(e, 1'b1);
    apb(1'b1, 8'hA8, 8'hBF);
    apb(1'b0, 8'hA8, 8'h00);
    chk(r, 32'hBF);
  endtask : s_regs
  task s_calls;
    apb(1'b1, 8'hA8, 8'h02);
    fl <= 4'h1;
    wv(20);
    chk(got, 1'b0);
    apb(1'b1, 8'hA8, 8'h8A);
    wv(20);
    chk({got, src, lvl}, {1'b1, 3'h1, 2'h0});
    fl <= 4'h2;
    wv(20);
    chk(got, 1'b0);
    apb(1'b1, 8'hB7, 8'h08);
    apb(1'b1, 8'hB8, 8'h08);
    wv(20);
    chk({got, src, lvl}, {1'b1, 3'h3, 2'h3});
    fl <= 4'h0;
    pulse_ret();
    pulse_ret();
  endtask : s_calls
  task s_ext0;
    apb(1'b1, 8'hA8, 8'h81);
    apb(1'b1, 8'h88, 8'h01);
    pin0 <= 1'b0;
    wv(20);
    chk({got, src}, {1'b1, 3'h0});
    apb(1'b0, 8'h88, 8'h00);
    chk(r, 32'h01);
    pulse_ret();
    apb(1'b1, 8'hA1, 8'h01);
    pin0 <= 1'b1;
    wv(20);
    chk(got, 1'b1);
    pulse_ret();
  endtask : s_ext0
  task s_ext2;
    apb(1'b1, 8'hA8, 8'h00);
    apb(1'b1, 8'hD1, 8'h04);
    apb(1'b1, 8'hC0, 8'h01);
    idle <= 1'b1;
    pin2 <= 1'b0;
    repeat (6) @(posedge clk_in);
    chk({wake, irq}, 2'h1);
    apb(1'b0, 8'hC0, 8'h00);
    chk(r, 32'h03);
    apb(1'b1, 8'hD0, 8'h04);
    repeat (2) @(posedge clk_in);
    chk(irq, 1'b0);
    apb(1'b1, 8'hC0, 8'h05);
    pin2 <= 1'b1;
    repeat (3) @(posedge clk_in);
    pin2 <= 1'b0;
    repeat (6) @(posedge clk_in);
    chk(wake, 1'b1);
    idle <= 1'b0;
  endtask : s_ext2
  initial begin
    {rst_n_in, psel, pen, pwr, ret, idle} = '0;
    {pin0, pin2, pa, pwd, fl, err_count, checked} = '0;
    pin0 = 1'b1;
    pin2 = 1'b1;
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1'b1;
    s_regs();
    s_calls();
    s_ext0();
    s_ext2();
    tally_and_finish();
  end
endmodule : intarb_tb_top
bind intarb_top intarb_chk u_chk (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
  .penable_in(penable_in), .pready_out(pready_out), .pslverr_out(pslverr_out),
  .cpu_last_cycle_in(cpu_last_cycle_in), .cpu_reti_in(cpu_reti_in), .vec_req_out(vec_req_out),
  .vec_src_out(vec_src_out), .irq_out(irq_out));
`default_nettype wire
